// File: hdl/mcfl_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  motor current foldback and logs block.
  Assumes a byte-addressed 8-bit register port with 32-bit words.
*/
`ifndef MCFL_REGS_SVH
`define MCFL_REGS_SVH

// register byte offsets
`define MCFL_OFS_MAX_CUR    8'h00
`define MCFL_OFS_FB_TIME    8'h04
`define MCFL_OFS_FB_LEVEL   8'h08
`define MCFL_OFS_FB_THR     8'h0C
`define MCFL_OFS_COMP       8'h10
`define MCFL_OFS_CTRL       8'h14
`define MCFL_OFS_TORQUE     8'h18
`define MCFL_OFS_DAMP       8'h1C
`define MCFL_OFS_SVC_INT    8'h20
`define MCFL_OFS_SVC_LOG    8'h24
`define MCFL_OFS_HOURS      8'h28
`define MCFL_OFS_CMD        8'h2C
`define MCFL_OFS_STATUS     8'h30
`define MCFL_LOG_BASE_SEL   3'h2

// control and command bit positions
`define MCFL_CTRL_INV_L     0
`define MCFL_CTRL_INV_R     1
`define MCFL_CTRL_SWAP      2
`define MCFL_CMD_CLR_HOURS  0
`define MCFL_CMD_ERASE_LOG  1

// setting ranges and reset values
`define MCFL_MAX_LO         8'h14
`define MCFL_MAX_HI         8'h32
`define MCFL_TIME_LO        8'h01
`define MCFL_TIME_HI        8'hFA
`define MCFL_LEVEL_LO       8'h19
`define MCFL_LEVEL_HI       8'h64
`define MCFL_PCT_HI         8'h64
`define MCFL_THR_LO         8'h14
`define MCFL_RST_MAX        6'h32
`define MCFL_RST_TIME       8'h0F
`define MCFL_RST_LEVEL      7'h64
`define MCFL_RST_THR        6'h28

// timing
`define MCFL_CLK_HZ         100000000
`define MCFL_TICK_S         1
`define MCFL_HOUR_S         3600
`define MCFL_COOL_MUL       5

`endif

// File: hdl/mcfl_pkg.sv
/*
  Types of the motor current foldback and logs block.
  Assumes mcfl_regs.svh for all figures.
*/
`default_nettype none

package mcfl_pkg;

	typedef struct packed {
		logic [5:0] cfg_max;
		logic [7:0] fb_time;
		logic [6:0] fb_level;
		logic [5:0] fb_thr;
		logic [7:0] comp;
		logic inv_l;
		logic inv_r;
		logic swap;
		logic [6:0] torque;
		logic [6:0] damp;
		logic [13:0] svc_int;
		logic [15:0] svc_log;
		logic [15:0] hours;
		logic [11:0] sec_in_hour;
		logic [26:0] tick;
		logic [7:0] fb_sec;
		logic [10:0] cool;
		logic fb_active;
		logic boost_on;
		logic [8:0] limit;
		logic [15:0] filt_l;
		logic [15:0] filt_r;
		logic [7:0] drv_l;
		logic [7:0] drv_r;
		logic [7:0][7:0] log_code;
		logic [7:0][7:0] log_cnt;
		logic [31:0] rdata;
	} mcfl_state_t;

endpackage

`default_nettype wire

// File: hdl/mcfl_core.sv
/*
  Motor output policy and memory functions: current limit with timed
  foldback, stall boost, tremor damping, channel invert and swap, usage
  hours, diagnostic log and service log, all behind a strobe register port.
  Assumes the current sample, stall flag, joystick flag and fault events
  come from logic on clock_in, and that the master keeps the strobe rules.
*/
// Notes on behaviour
// - max current limit settable 20 to 50 A in 1 A steps
// - foldback time settable 1 to 250 seconds
// - foldback level settable 25 to 100 percent of max current
// - foldback threshold settable from 20 A up to max current
// - current over threshold longer than time caps output at level
// - reduced limit held for five times the foldback time, then full
// - level of 100 percent keeps the limit at full max in foldback, but stall boost stays off
// - left invert reverses left output polarity
// - right invert reverses right output polarity
// - swap exchanges left and right drives
// - stall outside foldback raises limit by torque percent, zero adds nothing
// - damping 0 to 100 percent, some damping always remains
// - usage hours count only while joystick deflected
// - clear command zeroes usage hours
// - log keeps counts of the eight latest distinct problems, readable
// - erase command clears the whole log
// - writing service interval copies usage hours into service log
// - programmer can read and clear timer and log
`timescale 1ns/10ps
`default_nettype none
`include "mcfl_regs.svh"

module mcfl_core
	import mcfl_pkg::*;
#(
	parameter int TICK_CYCLES = `MCFL_TICK_S * `MCFL_CLK_HZ
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// motor side
	input wire logic [7:0] motor_current_in,
	input wire logic stall_in,
	input wire logic [7:0] left_motor_channel_in,
	input wire logic [7:0] right_motor_channel_in,
	output logic [8:0] current_limit_out,
	output logic [7:0] left_motor_channel_out,
	output logic [7:0] right_motor_channel_out,
	output logic [7:0] comp_out,
	output logic foldback_active_out,
	// usage and problems
	input wire logic joystick_deflected_in,
	input wire logic fault_event_in,
	input wire logic [7:0] fault_code_in
);

	mcfl_state_t s;
	mcfl_state_t n;

	logic over;
	logic tick_hit;
	logic hour_roll;
	logic cmd_wr;
	logic [10:0] cool_lim;
	logic [8:0] full;
	logic [8:0] fold;
	logic [8:0] boost;
	logic [15:0] prod;
	logic [2:0] sh;
	logic [7:0] tmp;
	logic hit;
	logic [2:0] hit_idx;
	logic [7:0] pre_l;
	logic [7:0] pre_r;

	function automatic logic [7:0] clampv(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// first-order low pass; shift never below one keeps some damping
	function automatic logic [15:0] lowpass(input logic [15:0] f, input logic [7:0] x,
		input logic [2:0] k);
		logic signed [16:0] diff;
		logic signed [16:0] step;
		diff = $signed({x[7], x, 8'h00}) - $signed({f[15], f});
		step = diff >>> k;
		lowpass = f + step[15:0];
	endfunction

	// saturating negate so full reverse maps to full forward 7F instead of wrapping back to full reverse
	function automatic logic [7:0] neg8(input logic [7:0] x);
		neg8 = (x == 8'h80) ? 8'h7F : (~x + 8'h01);
	endfunction

	always_comb begin
		n = s;
		tmp = 8'h00;
		hit = 1'b0;
		hit_idx = 3'h0;
		cmd_wr = reg_wr_in && (reg_addr_in == `MCFL_OFS_CMD);
		over = motor_current_in > {2'h0, s.fb_thr};
		tick_hit = s.tick == 27'(TICK_CYCLES - 1);
		n.tick = tick_hit ? 27'h0 : s.tick + 27'h1;
		cool_lim = 11'({3'h0, s.fb_time} * 11'(`MCFL_COOL_MUL));

		// foldback timer and cool-down
		if (!s.fb_active) begin
			if (!over) begin
				n.fb_sec = 8'h00;
			end else if (tick_hit) begin
				if (s.fb_sec + 8'h01 >= s.fb_time) begin
					n.fb_active = 1'b1;
					n.cool = 11'h000;
				end else begin
					n.fb_sec = s.fb_sec + 8'h01;
				end
			end
		end else if (tick_hit) begin
			if (s.cool + 11'h001 >= cool_lim) begin
				n.fb_active = 1'b0;
				n.fb_sec = 8'h00;
			end else begin
				n.cool = s.cool + 11'h001;
			end
		end

		// usage hours; a clear in the roll cycle still keeps the new hour
		hour_roll = tick_hit && joystick_deflected_in
			&& (s.sec_in_hour == 12'(`MCFL_HOUR_S - 1));
		if (tick_hit && joystick_deflected_in) begin
			n.sec_in_hour = hour_roll ? 12'h000 : s.sec_in_hour + 12'h001;
		end
		if (cmd_wr && reg_wdata_in[`MCFL_CMD_CLR_HOURS]) begin
			n.hours = 16'h0000;
			if (!hour_roll) begin
				n.sec_in_hour = 12'h000;
			end
		end
		if (hour_roll) begin
			n.hours = n.hours + 16'h0001;
		end

		// settings other than comp, control and service interval, clamped to their legal ranges
		if (reg_wr_in) begin
			if (reg_addr_in == `MCFL_OFS_MAX_CUR) begin
				tmp = clampv(reg_wdata_in[7:0], `MCFL_MAX_LO, `MCFL_MAX_HI);
				n.cfg_max = tmp[5:0];
			end else if (reg_addr_in == `MCFL_OFS_FB_TIME) begin
				n.fb_time = clampv(reg_wdata_in[7:0], `MCFL_TIME_LO, `MCFL_TIME_HI);
			end else if (reg_addr_in == `MCFL_OFS_FB_LEVEL) begin
				tmp = clampv(reg_wdata_in[7:0], `MCFL_LEVEL_LO, `MCFL_LEVEL_HI);
				n.fb_level = tmp[6:0];
			end else if (reg_addr_in == `MCFL_OFS_FB_THR) begin
				tmp = clampv(reg_wdata_in[7:0], `MCFL_THR_LO, {2'h0, s.cfg_max});
				n.fb_thr = tmp[5:0];
			end else if (reg_addr_in == `MCFL_OFS_COMP) begin
				n.comp = reg_wdata_in[7:0]; // range is the programmer's duty
			end else if (reg_addr_in == `MCFL_OFS_CTRL) begin
				n.inv_l = reg_wdata_in[`MCFL_CTRL_INV_L];
				n.inv_r = reg_wdata_in[`MCFL_CTRL_INV_R];
				n.swap = reg_wdata_in[`MCFL_CTRL_SWAP];
			end else if (reg_addr_in == `MCFL_OFS_TORQUE) begin
				tmp = clampv(reg_wdata_in[7:0], 8'h00, `MCFL_PCT_HI);
				n.torque = tmp[6:0];
			end else if (reg_addr_in == `MCFL_OFS_DAMP) begin
				tmp = clampv(reg_wdata_in[7:0], 8'h00, `MCFL_PCT_HI);
				n.damp = tmp[6:0];
			end else if (reg_addr_in == `MCFL_OFS_SVC_INT) begin
				n.svc_int = reg_wdata_in[13:0];
				n.svc_log = s.hours;
			end
		end
		// lowering the max drags the threshold with it
		if (n.fb_thr > n.cfg_max) begin
			n.fb_thr = n.cfg_max;
		end

		// diagnostic log: erase first so a same-cycle problem is kept
		if (cmd_wr && reg_wdata_in[`MCFL_CMD_ERASE_LOG]) begin
			n.log_cnt = '0;
			n.log_code = '0;
		end
		if (fault_event_in) begin
			for (int i = 0; i < 8; i++) begin
				if (!hit && n.log_cnt[i] != 8'h00 && n.log_code[i] == fault_code_in) begin
					hit = 1'b1;
					hit_idx = 3'(i);
				end
			end
			if (hit) begin
				if (n.log_cnt[hit_idx] != 8'hFF) begin
					n.log_cnt[hit_idx] = n.log_cnt[hit_idx] + 8'h01;
				end
			end else begin
				for (int i = 7; i > 0; i--) begin
					n.log_code[i] = n.log_code[i - 1];
					n.log_cnt[i] = n.log_cnt[i - 1];
				end
				n.log_code[0] = fault_code_in;
				n.log_cnt[0] = 8'h01;
			end
		end

		// current limit in half amps so 12.5 A is exact
		full = {2'h0, s.cfg_max, 1'b0};
		prod = 16'(full) * {9'h000, s.fb_level};
		fold = 9'(prod / 16'h0064);
		prod = 16'(full) * {9'h000, s.torque};
		boost = 9'(prod / 16'h0064);
		n.boost_on = stall_in && !s.fb_active && (s.torque != 7'h00);
		if (s.fb_active) begin
			n.limit = (fold < full) ? fold : full;
		end else if (stall_in) begin
			n.limit = full + boost;
		end else begin
			n.limit = full;
		end

		// damping then routing; swap precedes the per-output invert
		sh = 3'h1 + 3'(s.damp / 7'h19);
		n.filt_l = lowpass(s.filt_l, left_motor_channel_in, sh);
		n.filt_r = lowpass(s.filt_r, right_motor_channel_in, sh);
		pre_l = s.swap ? s.filt_r[15:8] : s.filt_l[15:8];
		pre_r = s.swap ? s.filt_l[15:8] : s.filt_r[15:8];
		n.drv_l = s.inv_l ? neg8(pre_l) : pre_l;
		n.drv_r = s.inv_r ? neg8(pre_r) : pre_r;

		// read data for the next cycle only
		n.rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			if (reg_addr_in == `MCFL_OFS_MAX_CUR) begin
				n.rdata = {26'h0, s.cfg_max};
			end else if (reg_addr_in == `MCFL_OFS_FB_TIME) begin
				n.rdata = {24'h0, s.fb_time};
			end else if (reg_addr_in == `MCFL_OFS_FB_LEVEL) begin
				n.rdata = {25'h0, s.fb_level};
			end else if (reg_addr_in == `MCFL_OFS_FB_THR) begin
				n.rdata = {26'h0, s.fb_thr};
			end else if (reg_addr_in == `MCFL_OFS_COMP) begin
				n.rdata = {24'h0, s.comp};
			end else if (reg_addr_in == `MCFL_OFS_CTRL) begin
				n.rdata = {29'h0, s.swap, s.inv_r, s.inv_l};
			end else if (reg_addr_in == `MCFL_OFS_TORQUE) begin
				n.rdata = {25'h0, s.torque};
			end else if (reg_addr_in == `MCFL_OFS_DAMP) begin
				n.rdata = {25'h0, s.damp};
			end else if (reg_addr_in == `MCFL_OFS_SVC_INT) begin
				n.rdata = {18'h0, s.svc_int};
			end else if (reg_addr_in == `MCFL_OFS_SVC_LOG) begin
				n.rdata = {16'h0, s.svc_log};
			end else if (reg_addr_in == `MCFL_OFS_HOURS) begin
				n.rdata = {16'h0, s.hours};
			end else if (reg_addr_in == `MCFL_OFS_STATUS) begin
				n.rdata = {30'h0, s.boost_on, s.fb_active};
			end else if (reg_addr_in[7:5] == `MCFL_LOG_BASE_SEL) begin
				n.rdata = {16'h0, s.log_code[reg_addr_in[4:2]],
					s.log_cnt[reg_addr_in[4:2]]};
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
			s.cfg_max <= `MCFL_RST_MAX;
			s.fb_time <= `MCFL_RST_TIME;
			s.fb_level <= `MCFL_RST_LEVEL;
			s.fb_thr <= `MCFL_RST_THR;
			s.limit <= {2'h0, `MCFL_RST_MAX, 1'b0};
		end else begin
			s <= n;
		end
	end

	assign reg_rdata_out = s.rdata;
	assign current_limit_out = s.limit;
	assign left_motor_channel_out = s.drv_l;
	assign right_motor_channel_out = s.drv_r;
	assign comp_out = s.comp;
	assign foldback_active_out = s.fb_active;

	a_engage_needs_over: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(s.fb_active) |-> $past(over) && $past(tick_hit))
		else $error("foldback engaged without over-threshold current");

	a_timer_restart: assert property (@(posedge clock_in) disable iff (rst_in)
		(!s.fb_active && !over) |=> (s.fb_sec == 8'h00))
		else $error("foldback timer not restarted below threshold");

	a_cool_hold: assert property (@(posedge clock_in) disable iff (rst_in)
		(s.fb_active && !(tick_hit && (s.cool + 11'h001 >= cool_lim)))
		|=> s.fb_active)
		else $error("foldback released before cool-down ended");

	a_level_full_limit: assert property (@(posedge clock_in) disable iff (rst_in)
		(s.fb_active && s.fb_level == 7'h64)
		|=> (s.limit == {2'h0, $past(s.cfg_max), 1'b0}))
		else $error("full level still reduced the limit");

	a_fold_limit: assert property (@(posedge clock_in) disable iff (rst_in)
		s.fb_active |=> (s.limit <= {2'h0, $past(s.cfg_max), 1'b0}))
		else $error("limit above max during foldback");

	a_zero_torque: assert property (@(posedge clock_in) disable iff (rst_in)
		(stall_in && s.torque == 7'h00 && !s.fb_active)
		|=> (s.limit == {2'h0, $past(s.cfg_max), 1'b0}))
		else $error("zero torque setting added boost");

	a_hours_stop: assert property (@(posedge clock_in) disable iff (rst_in)
		(!joystick_deflected_in && !cmd_wr) |=> $stable(s.hours))
		else $error("hours moved with joystick released");

	a_hours_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		(cmd_wr && reg_wdata_in[`MCFL_CMD_CLR_HOURS] && !hour_roll)
		|=> (s.hours == 16'h0000))
		else $error("clear did not zero the hours");

	a_log_erase: assert property (@(posedge clock_in) disable iff (rst_in)
		(cmd_wr && reg_wdata_in[`MCFL_CMD_ERASE_LOG] && !fault_event_in)
		|=> (s.log_cnt == '0) && (s.log_code == '0))
		else $error("erase left log entries");

	a_service_copy: assert property (@(posedge clock_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == `MCFL_OFS_SVC_INT)
		|=> (s.svc_log == $past(s.hours)))
		else $error("service log missed the hours");

	a_swap_route: assert property (@(posedge clock_in) disable iff (rst_in)
		(s.swap && !s.inv_l) |=> (s.drv_l == $past(s.filt_r[15:8])))
		else $error("swap did not route right drive to left");

	a_read_late: assert property (@(posedge clock_in) disable iff (rst_in)
		!reg_rd_in |=> (reg_rdata_out == 32'h0000_0000))
		else $error("read data outside the answer cycle");

endmodule // mcfl_core

`default_nettype wire

// File: verif/mcfl_prog_model.sv
/*
  Model of the configuration programmer: drives register writes and reads.
  Assumes the core's strobe port on the same clock, answer one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none

module mcfl_prog_model (
	// clock
	input wire logic clock_in,
	// register port
	input wire logic [31:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic [31:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 32'h00000000;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end

	// caller keeps compensation within 70 percent of loop resistance
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge clock_in);
		reg_wr_out <= 1'b0;
		// stale data inverted so a late sample cannot pass
		reg_wdata_out <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clock_in);
		reg_rd_out <= 1'b0;
		#1 d = reg_rdata_in;
	endtask
endmodule // mcfl_prog_model

`default_nettype wire

// File: verif/motor_current_foldback_and_logs_bench.sv
/*
  Self-checking bench of the foldback and logs core.
  Assumes the core's register map and a short tick parameter.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mcfl_regs.svh"

module motor_current_foldback_and_logs_bench;
	localparam int TICK = 4;
	localparam logic [7:0] OFS [11] = '{`MCFL_OFS_MAX_CUR, `MCFL_OFS_MAX_CUR, `MCFL_OFS_FB_TIME,
		`MCFL_OFS_FB_TIME, `MCFL_OFS_FB_LEVEL, `MCFL_OFS_FB_LEVEL, `MCFL_OFS_MAX_CUR,
		`MCFL_OFS_FB_THR, `MCFL_OFS_FB_THR, `MCFL_OFS_TORQUE, `MCFL_OFS_DAMP};
	localparam logic [7:0] WV [11] = '{8'h10, 8'h40, 8'h00, 8'hFF, 8'h10, 8'h65, 8'h1E, 8'h3F,
		8'h05, 8'h80, 8'hC8};
	localparam logic [7:0] EV [11] = '{8'h14, 8'h32, 8'h01, 8'hFA, 8'h19, 8'h64, 8'h1E, 8'h1E,
		8'h14, 8'h64, 8'h64};
	logic clock_in, rst_in, reg_wr, reg_rd, stall, joy, fault_ev, fb_act;
	logic [7:0] reg_addr, cur, drv_l, drv_r, code, out_l, out_r, comp;
	logic [31:0] reg_wdata, reg_rdata, rd_val, seed;
	logic [8:0] limit;
	int bad_count, n_checks, n;
	int code_q[$], cnt_q[$];

	mcfl_core #(.TICK_CYCLES(TICK)) mcfl_core_i (
		.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.motor_current_in(cur), .stall_in(stall), .left_motor_channel_in(drv_l),
		.right_motor_channel_in(drv_r), .current_limit_out(limit),
		.left_motor_channel_out(out_l), .right_motor_channel_out(out_r), .comp_out(comp),
		.foldback_active_out(fb_act), .joystick_deflected_in(joy),
		.fault_event_in(fault_ev), .fault_code_in(code));

	mcfl_prog_model mcfl_prog_model_i (
		.clock_in(clock_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic bit near(input logic [7:0] g, input int e);
		int d;
		d = int'($signed(g)) - e;
		return d >= -2 && d <= 2;
	endfunction

	task automatic close_out;
		if (bad_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_near(input logic [7:0] got, input int exp);
		n_checks++;
		if (!near(got, exp)) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp[7:0]);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		mcfl_prog_model_i.write_reg(a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		mcfl_prog_model_i.read_reg(a, rd_val);
		chk(rd_val, e);
	endtask

	// bounded wait on the foldback flag, k counts cycles spent
	task automatic wait_fb(input logic lvl, input int lim, output int k);
		k = 0;
		while (fb_act !== lvl) begin
			@(posedge clock_in);
			#1 k++;
			if (k > lim) begin
				bad_count++;
				close_out();
			end
		end
	endtask

	initial begin
		int a, b, el, er, k, idx;
		int steps[2];
		rst_in = 1'b1;
		cur = 8'h00;
		stall = 1'b0;
		joy = 1'b0;
		fault_ev = 1'b0;
		code = 8'h00;
		drv_l = 8'h00;
		drv_r = 8'h00;
		seed = 32'h5256EFA5;
		bad_count = 0;
		n_checks = 0;
		cyc(5);
		rst_in <= 1'b0;
		#1 chk(limit, 9'h064);
		rdc(`MCFL_OFS_MAX_CUR, 32'h32);
		rdc(`MCFL_OFS_FB_TIME, 32'h0F);
		rdc(`MCFL_OFS_FB_LEVEL, 32'h64);
		rdc(`MCFL_OFS_FB_THR, 32'h28);
		for (int i = 0; i < 11; i++) begin
			wr(OFS[i], {24'h000000, WV[i]});
			rdc(OFS[i], {24'h000000, EV[i]});
		end
		wr(`MCFL_OFS_COMP, 32'hAA);
		#1 chk(comp, 8'hAA);
		wr(`MCFL_OFS_HOURS, 32'h05);
		rdc(`MCFL_OFS_HOURS, 32'h00);
		rdc(8'h60, 32'h00);
		// max 40 A, threshold 20 A, 3 s, 50 percent
		wr(`MCFL_OFS_MAX_CUR, 32'h28);
		wr(`MCFL_OFS_FB_THR, 32'h14);
		wr(`MCFL_OFS_FB_TIME, 32'h03);
		wr(`MCFL_OFS_FB_LEVEL, 32'h32);
		wr(`MCFL_OFS_DAMP, 32'h00);
		// two ticks over, then under: timer must restart each time
		for (int i = 0; i < 5; i++) begin
			cur <= 8'h1E;
			cyc(8);
			cur <= 8'h0A;
			cyc(8);
			#1 chk(fb_act, 1'b0);
		end
		cur <= 8'h1E;
		wait_fb(1'b1, 40, n);
		chk(n >= 8, 1'b1);
		cyc(2);
		#1 chk(limit, 9'h028);
		rdc(`MCFL_OFS_STATUS, 32'h01);
		wait_fb(1'b0, 80, n);
		chk(n >= 52 && n <= 68, 1'b1);
		cyc(2);
		#1 chk(limit, 9'h050);
		wr(`MCFL_OFS_FB_LEVEL, 32'h64);
		wait_fb(1'b1, 40, n);
		cyc(2);
		#1 chk(limit, 9'h050);
		cur <= 8'h0A;
		wait_fb(1'b0, 80, n);
		for (int t = 0; t < 3; t++) begin
			wr(`MCFL_OFS_TORQUE, 32'(t * 50));
			stall <= 1'b1;
			cyc(4);
			#1 chk(limit, 32'(80 + 80 * t * 50 / 100));
			rdc(`MCFL_OFS_STATUS, (t > 0) ? 32'h02 : 32'h00);
			stall <= 1'b0;
		end
		for (int c = 0; c < 8; c++) begin
			seed = nxt(seed);
			a = int'(seed[7:0]) % 201 - 100;
			b = int'(seed[15:8]) % 201 - 100;
			wr(`MCFL_OFS_CTRL, 32'(c));
			drv_l <= a[7:0];
			drv_r <= b[7:0];
			cyc(60);
			el = c[2] ? b : a;
			er = c[2] ? a : b;
			el = c[0] ? -el : el;
			er = c[1] ? -er : er;
			#1 chk_near(out_l, el);
			chk_near(out_r, er);
			rdc(`MCFL_OFS_CTRL, 32'(c));
		end
		wr(`MCFL_OFS_CTRL, 32'h00);
		for (int j = 0; j < 2; j++) begin
			wr(`MCFL_OFS_DAMP, 32'(j * 100));
			drv_l <= 8'h00;
			cyc(400);
			drv_l <= 8'h64;
			k = 0;
			while (!near(out_l, 100) && k < 1000) begin
				@(posedge clock_in);
				#1 k++;
			end
			if (k >= 1000) begin
				bad_count++;
				close_out();
			end
			steps[j] = k;
		end
		chk(steps[0] >= 2, 1'b1);
		chk(steps[1] > steps[0] && steps[1] < 1000, 1'b1);
		// 3000 ticks deflected, then released long enough to pass an hour
		joy <= 1'b1;
		cyc(12000);
		joy <= 1'b0;
		cyc(8000);
		rdc(`MCFL_OFS_HOURS, 32'h00);
		joy <= 1'b1;
		cyc(3000);
		joy <= 1'b0;
		rdc(`MCFL_OFS_HOURS, 32'h01);
		wr(`MCFL_OFS_SVC_INT, 32'h3E8);
		rdc(`MCFL_OFS_SVC_LOG, 32'h01);
		wr(`MCFL_OFS_CMD, 32'h01);
		rdc(`MCFL_OFS_HOURS, 32'h00);
		for (int i = 0; i < 20; i++) begin
			seed = nxt(seed);
			@(posedge clock_in);
			fault_ev <= 1'b1;
			code <= {4'h0, seed[3:0]};
			@(posedge clock_in);
			fault_ev <= 1'b0;
			idx = -1;
			foreach (code_q[j]) begin
				if (code_q[j] == int'(seed[3:0])) begin
					idx = j;
				end
			end
			if (idx < 0) begin
				code_q.push_front(int'(seed[3:0]));
				cnt_q.push_front(1);
				if (code_q.size() > 8) begin
					void'(code_q.pop_back());
					void'(cnt_q.pop_back());
				end
			end else if (cnt_q[idx] < 255) begin
				cnt_q[idx]++;
			end
		end
		for (int i = 0; i < 8; i++) begin
			rdc(8'(8'h40 + 4 * i), i < code_q.size() ? 32'(code_q[i] * 256 + cnt_q[i]) : 32'h0);
		end
		wr(`MCFL_OFS_CMD, 32'h02);
		for (int i = 0; i < 8; i++) begin
			rdc(8'(8'h40 + 4 * i), 32'h00);
		end
		close_out();
	end
endmodule // motor_current_foldback_and_logs_bench

`default_nettype wire
